// File: rtl/temp_threshold_compare_counter.sv
// temperature threshold compare, event flags, low event counter, avalon slave
// How it works
// - The low threshold is an 8-bit two's complement register, -128 to 127 in 1 degree steps.
// - The high threshold is an 8-bit two's complement register in the same encoding.
// - A low event is raised when the signed temperature is strictly below the low threshold.
// - Both thresholds always read back, and writes to them are dropped while protected.
// - The low event counter counts low events as an unsigned value from 0 to 255.
// - The low event counter is read only and writes to it change nothing.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ns
module temp_threshold_compare_counter (
    input wire logic clk,
    input wire logic rst,
    input wire logic [temp_cmp_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [temp_cmp_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [temp_cmp_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [temp_cmp_pkg::REG_W-1:0] temp_int,
    input wire logic write_protect,
    output temp_cmp_pkg::event_flags_t event_pulse,
    output logic irq
);

    // ==========================================================
    // functions
    function automatic logic hit(input logic [temp_cmp_pkg::ADDR_W-1:0] addr,
                                 input logic [temp_cmp_pkg::IDX_W-1:0] idx);
        hit = (addr[temp_cmp_pkg::ADDR_W-1:temp_cmp_pkg::IDX_LSB] == idx);
    endfunction

    function automatic logic signed_below(input logic [temp_cmp_pkg::REG_W-1:0] a,
                                          input logic [temp_cmp_pkg::REG_W-1:0] b);
        signed_below = ($signed(a) < $signed(b));
    endfunction

    function automatic logic [temp_cmp_pkg::DATA_W-1:0] widen(
        input logic [temp_cmp_pkg::REG_W-1:0] v);
        widen = {{(temp_cmp_pkg::DATA_W-temp_cmp_pkg::REG_W){1'b0}}, v};
    endfunction

    // ==========================================================
    // state
    temp_cmp_pkg::bus_state_t bus_state;
    temp_cmp_pkg::bus_state_t next_bus_state;
    logic next_waitrequest;
    logic [temp_cmp_pkg::DATA_W-1:0] next_readdata;

    logic [temp_cmp_pkg::REG_W-1:0] low_temp_threshold;
    logic [temp_cmp_pkg::REG_W-1:0] high_temp_threshold;
    logic [temp_cmp_pkg::REG_W-1:0] next_low_temp_threshold;
    logic [temp_cmp_pkg::REG_W-1:0] next_high_temp_threshold;
    logic low_stamp_enable;
    logic next_low_stamp_enable;
    logic [temp_cmp_pkg::EVT_W-1:0] status;
    logic [temp_cmp_pkg::EVT_W-1:0] next_status;
    logic [temp_cmp_pkg::EVT_W-1:0] mask;
    logic [temp_cmp_pkg::EVT_W-1:0] next_mask;
    logic next_irq;

    temp_cmp_pkg::event_flags_t cond;
    temp_cmp_pkg::event_flags_t cond_prev;
    temp_cmp_pkg::event_flags_t rise;
    temp_cmp_pkg::event_flags_t next_event_pulse;
    logic [temp_cmp_pkg::REG_W-1:0] low_event_counter;

    logic wr_take;
    logic wr_lane0;
    logic [temp_cmp_pkg::EVT_W-1:0] set_bits;
    logic [temp_cmp_pkg::EVT_W-1:0] clr_bits;

    // ==========================================================
    // bus handshake: one wait state, answer in the second cycle
    always_comb begin
        next_bus_state = bus_state;
        next_waitrequest = avs_waitrequest;
        next_readdata = avs_readdata;
        case (bus_state)
            temp_cmp_pkg::BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    next_bus_state = temp_cmp_pkg::BUS_ACK;
                    next_waitrequest = 1'b0;
                    next_readdata = temp_cmp_pkg::READ_ZERO;
                    if (avs_read) begin
                        if (hit(avs_address, temp_cmp_pkg::IDX_LOW_THR)) begin
                            next_readdata = widen(low_temp_threshold);
                        end else if (hit(avs_address, temp_cmp_pkg::IDX_HIGH_THR)) begin
                            next_readdata = widen(high_temp_threshold);
                        end else if (hit(avs_address, temp_cmp_pkg::IDX_LOW_CNT)) begin
                            next_readdata = widen(low_event_counter);
                        end else if (hit(avs_address, temp_cmp_pkg::IDX_CONTROL)) begin
                            next_readdata[temp_cmp_pkg::CTRL_LOW_STAMP_EN] = low_stamp_enable;
                        end else if (hit(avs_address, temp_cmp_pkg::IDX_STATUS)) begin
                            next_readdata[temp_cmp_pkg::EVT_W-1:0] = status;
                        end else if (hit(avs_address, temp_cmp_pkg::IDX_MASK)) begin
                            next_readdata[temp_cmp_pkg::EVT_W-1:0] = mask;
                        end
                    end
                end
            end
            temp_cmp_pkg::BUS_ACK: begin
                next_bus_state = temp_cmp_pkg::BUS_IDLE;
                next_waitrequest = 1'b1;
            end
            default: begin
                next_bus_state = temp_cmp_pkg::BUS_IDLE;
                next_waitrequest = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_state <= temp_cmp_pkg::BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= temp_cmp_pkg::READ_ZERO;
        end else begin
            bus_state <= next_bus_state;
            avs_waitrequest <= next_waitrequest;
            avs_readdata <= next_readdata;
        end
    end

    // ==========================================================
    // register writes, taken at the edge where waitrequest is low
    assign wr_take = avs_write && (bus_state == temp_cmp_pkg::BUS_ACK);
    assign wr_lane0 = wr_take && avs_byteenable[0];

    always_comb begin
        next_low_temp_threshold = low_temp_threshold;
        next_high_temp_threshold = high_temp_threshold;
        next_low_stamp_enable = low_stamp_enable;
        next_mask = mask;
        clr_bits = temp_cmp_pkg::EVT_NONE;
        if (wr_lane0 && !write_protect) begin
            if (hit(avs_address, temp_cmp_pkg::IDX_LOW_THR)) begin
                next_low_temp_threshold = avs_writedata[temp_cmp_pkg::REG_W-1:0];
            end
            if (hit(avs_address, temp_cmp_pkg::IDX_HIGH_THR)) begin
                next_high_temp_threshold = avs_writedata[temp_cmp_pkg::REG_W-1:0];
            end
        end
        if (wr_lane0) begin
            if (hit(avs_address, temp_cmp_pkg::IDX_CONTROL)) begin
                next_low_stamp_enable = avs_writedata[temp_cmp_pkg::CTRL_LOW_STAMP_EN];
            end
            if (hit(avs_address, temp_cmp_pkg::IDX_STATUS)) begin
                clr_bits = avs_writedata[temp_cmp_pkg::EVT_W-1:0];
            end
            if (hit(avs_address, temp_cmp_pkg::IDX_MASK)) begin
                next_mask = avs_writedata[temp_cmp_pkg::EVT_W-1:0];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_temp_threshold <= temp_cmp_pkg::RST_LOW_THR;
            high_temp_threshold <= temp_cmp_pkg::RST_HIGH_THR;
            low_stamp_enable <= 1'b0;
            mask <= temp_cmp_pkg::EVT_NONE;
        end else begin
            low_temp_threshold <= next_low_temp_threshold;
            high_temp_threshold <= next_high_temp_threshold;
            low_stamp_enable <= next_low_stamp_enable;
            mask <= next_mask;
        end
    end

    // ==========================================================
    // comparison and event detection
    always_comb begin
        cond.low = signed_below(temp_int, low_temp_threshold);
        cond.high = signed_below(high_temp_threshold, temp_int);
        rise.low = cond.low && !cond_prev.low;
        rise.high = cond.high && !cond_prev.high;
        next_event_pulse = rise;
        set_bits = temp_cmp_pkg::EVT_NONE;
        set_bits[temp_cmp_pkg::EVT_LOW] = rise.low;
        set_bits[temp_cmp_pkg::EVT_HIGH] = rise.high;
        // set wins over a clear in the same cycle
        next_status = (status & ~clr_bits) | set_bits;
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cond_prev <= '0;
            event_pulse <= '0;
            status <= temp_cmp_pkg::EVT_NONE;
            irq <= 1'b0;
        end else begin
            cond_prev <= cond;
            event_pulse <= next_event_pulse;
            status <= next_status;
            irq <= next_irq;
        end
    end

    // ==========================================================
    // low event counter, no write path reaches it
    low_event_count u_low_event_count (
        .clk(clk),
        .rst(rst),
        .low_event(rise.low),
        .low_stamp_enable(low_stamp_enable),
        .count(low_event_counter)
    );

    // ==========================================================
    // checks
    property p_low_thr_hold;
        @(posedge clk) disable iff (rst)
        !(wr_lane0 && hit(avs_address, temp_cmp_pkg::IDX_LOW_THR)) |=> $stable(low_temp_threshold);
    endproperty
    a_low_thr_hold: assert property (p_low_thr_hold) else $error("low threshold changed unasked");

    property p_high_thr_write;
        @(posedge clk) disable iff (rst)
        (wr_lane0 && !write_protect && hit(avs_address, temp_cmp_pkg::IDX_HIGH_THR))
        |=> (high_temp_threshold == $past(avs_writedata[temp_cmp_pkg::REG_W-1:0]));
    endproperty
    a_high_thr_write: assert property (p_high_thr_write) else $error("high threshold not written");

    property p_low_event;
        @(posedge clk) disable iff (rst)
        ($signed(temp_int) < $signed(low_temp_threshold)) && !cond_prev.low
        |=> event_pulse.low && status[temp_cmp_pkg::EVT_LOW];
    endproperty
    a_low_event: assert property (p_low_event) else $error("low event missed");

    property p_high_event;
        @(posedge clk) disable iff (rst)
        ($signed(temp_int) > $signed(high_temp_threshold)) && !cond_prev.high
        |=> event_pulse.high && status[temp_cmp_pkg::EVT_HIGH];
    endproperty
    a_high_event: assert property (p_high_event) else $error("high event missed");

    property p_no_false_low;
        @(posedge clk) disable iff (rst)
        !($signed(temp_int) < $signed(low_temp_threshold)) |=> !event_pulse.low;
    endproperty
    a_no_false_low: assert property (p_no_false_low) else $error("spurious low event");

    property p_protect;
        @(posedge clk) disable iff (rst)
        (wr_take && write_protect) |=> $stable(low_temp_threshold) && $stable(high_temp_threshold);
    endproperty
    a_protect: assert property (p_protect) else $error("protected threshold written");

    property p_count_ro;
        @(posedge clk) disable iff (rst)
        (wr_take && hit(avs_address, temp_cmp_pkg::IDX_LOW_CNT) && !rise.low)
        |=> $stable(low_event_counter);
    endproperty
    a_count_ro: assert property (p_count_ro) else $error("counter changed by a write");

    property p_count_enable;
        @(posedge clk) disable iff (rst)
        (rise.low && low_stamp_enable) |=> (low_event_counter != $past(low_event_counter));
    endproperty
    a_count_enable: assert property (p_count_enable) else $error("enabled counter stuck");

    property p_answer;
        @(posedge clk) disable iff (rst)
        (avs_read || avs_write) && avs_waitrequest && bus_state == temp_cmp_pkg::BUS_IDLE
        |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer not one cycle after request");

    property p_irq;
        @(posedge clk) disable iff (rst)
        irq == |(status & mask);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt disagrees with status and mask");

    c_low_counted: cover property (@(posedge clk) disable iff (rst)
        rise.low && low_stamp_enable ##1 event_pulse.low);
    c_high_event: cover property (@(posedge clk) disable iff (rst)
        rise.high ##1 irq);
    c_blocked_write: cover property (@(posedge clk) disable iff (rst)
        wr_take && write_protect && hit(avs_address, temp_cmp_pkg::IDX_LOW_THR));

endmodule // temp_threshold_compare_counter

// File: shared/temp_cmp_pkg.sv
// shared constants, types and register map of the temperature threshold block
package temp_cmp_pkg;

    // ==========================================================
    // bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 8;
    localparam int unsigned IDX_W = 6;
    localparam int unsigned IDX_LSB = 2;

    // ==========================================================
    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_LOW_THR = 6'h16;
    localparam logic [IDX_W-1:0] IDX_HIGH_THR = 6'h17;
    localparam logic [IDX_W-1:0] IDX_LOW_CNT = 6'h18;
    localparam logic [IDX_W-1:0] IDX_CONTROL = 6'h20;
    localparam logic [IDX_W-1:0] IDX_STATUS = 6'h21;
    localparam logic [IDX_W-1:0] IDX_MASK = 6'h22;

    // ==========================================================
    // reset values
    localparam logic [REG_W-1:0] RST_LOW_THR = 8'h00;
    localparam logic [REG_W-1:0] RST_HIGH_THR = 8'h00;
    localparam logic [REG_W-1:0] RST_LOW_CNT = 8'h00;
    localparam logic [REG_W-1:0] CNT_STEP = 8'h01;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    // ==========================================================
    // field positions
    localparam int unsigned CTRL_LOW_STAMP_EN = 0;
    localparam int unsigned EVT_LOW = 0;
    localparam int unsigned EVT_HIGH = 1;
    localparam int unsigned EVT_W = 2;
    localparam logic [EVT_W-1:0] EVT_NONE = 2'h0;

    // ==========================================================
    // types
    typedef struct packed {
        logic high;
        logic low;
    } event_flags_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

endpackage

// File: rtl/low_event_count.sv
// wrapping 8-bit counter of low temperature events
`timescale 1ns/1ns
module low_event_count (
    input wire logic clk,
    input wire logic rst,
    input wire logic low_event,
    input wire logic low_stamp_enable,
    output logic [temp_cmp_pkg::REG_W-1:0] count
);

    // ==========================================================
    // next value and register
    logic [temp_cmp_pkg::REG_W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (low_event && low_stamp_enable) begin
            // 255 wraps to 0 by the width of the sum
            next_count = temp_cmp_pkg::REG_W'(count + temp_cmp_pkg::CNT_STEP);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= temp_cmp_pkg::RST_LOW_CNT;
        end else begin
            count <= next_count;
        end
    end

    // ==========================================================
    // checks
    property p_count_step;
        @(posedge clk) disable iff (rst)
        (low_event && low_stamp_enable)
        |=> (count == temp_cmp_pkg::REG_W'($past(count) + temp_cmp_pkg::CNT_STEP));
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not step by one");

    property p_count_gate;
        @(posedge clk) disable iff (rst)
        !(low_event && low_stamp_enable) |=> $stable(count);
    endproperty
    a_count_gate: assert property (p_count_gate) else $error("counter moved while gated");

    c_count_wrap: cover property (@(posedge clk) disable iff (rst)
        (count == 8'hFF && low_event && low_stamp_enable) ##1 (count == 8'h00));

endmodule // low_event_count

// File: dv/host_model.sv
// avalon-mm host model issuing single register accesses
`timescale 1ns/1ns
module host_model (
    input wire logic clk,
    input wire logic avs_waitrequest,
    input wire logic [temp_cmp_pkg::DATA_W-1:0] avs_readdata,
    output logic [temp_cmp_pkg::ADDR_W-1:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [temp_cmp_pkg::DATA_W-1:0] avs_writedata,
    output logic [3:0] avs_byteenable
);
    logic hang;

    initial begin
        hang = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
    end

    // ==========================================================
    // bounded wait for the accepting edge
    task automatic wait_ack();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            hang = 1'b1;
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
        // released data no longer shows the written value
        avs_writedata <= ~d;
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_byteenable <= 4'hF;
        avs_read <= 1'b1;
        wait_ack();
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask
endmodule // host_model

// File: dv/temp_threshold_compare_counter_bench.sv
// self-checking bench of the temperature threshold block
`timescale 1ns/1ns
module temp_threshold_compare_counter_bench;
    localparam logic [7:0] LT = {temp_cmp_pkg::IDX_LOW_THR, 2'b00};
    localparam logic [7:0] HT = {temp_cmp_pkg::IDX_HIGH_THR, 2'b00};
    localparam logic [7:0] CNT = {temp_cmp_pkg::IDX_LOW_CNT, 2'b00};
    localparam logic [7:0] CTRL = {temp_cmp_pkg::IDX_CONTROL, 2'b00};
    localparam logic [7:0] STAT = {temp_cmp_pkg::IDX_STATUS, 2'b00};
    localparam logic [7:0] MASK = {temp_cmp_pkg::IDX_MASK, 2'b00};

    logic clk;
    logic rst;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] temp_int;
    logic write_protect;
    temp_cmp_pkg::event_flags_t event_pulse;
    logic irq;
    int failures;
    int checked;

    host_model host (
        .clk(clk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable)
    );

    temp_threshold_compare_counter dut (
        .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .temp_int(temp_int),
        .write_protect(write_protect), .event_pulse(event_pulse), .irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ==========================================================
    // checks and accesses
    task automatic summarize();
        if (failures == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        checked++;
        if (a !== e) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, a, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        host.bus_write(a, d, be);
        if (host.hang) begin
            failures++;
            summarize();
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        host.bus_read(a, v);
        if (host.hang) begin
            failures++;
            summarize();
        end
        chk(v, e);
    endtask

    // new temperature, then pulse one cycle later lasting one cycle
    task automatic step(input logic [7:0] v, input logic [1:0] e);
        @(posedge clk);
        temp_int <= v;
        @(posedge clk);
        #1;
        chk({30'h0, event_pulse}, {30'h0, e});
        @(posedge clk);
        #1;
        chk({30'h0, event_pulse}, 32'h0);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        failures = 0;
        checked = 0;
        rst = 1'b1;
        temp_int = 8'h00;
        write_protect = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdc(LT, 32'h0);
        rdc(HT, 32'h0);
        rdc(CNT, 32'h0);
        rdc(CTRL, 32'h0);
        rdc(STAT, 32'h0);
        rdc(MASK, 32'h0);
        wr(LT, 32'hFFFF_FF80, 4'hF);
        rdc(LT, 32'h80);
        wr(HT, 32'h7F, 4'hF);
        rdc(HT, 32'h7F);
        wr(8'hFC, 32'hFF, 4'hF);
        rdc(8'hFC, 32'h0);
        @(posedge clk);
        write_protect <= 1'b1;
        wr(LT, 32'h11, 4'hF);
        wr(HT, 32'h22, 4'hF);
        rdc(LT, 32'h80);
        rdc(HT, 32'h7F);
        @(posedge clk);
        write_protect <= 1'b0;
        wr(LT, 32'h11, 4'hE);
        rdc(LT, 32'h80);
        wr(LT, 32'hFB, 4'hF);
        wr(HT, 32'h1E, 4'hF);
        wr(CTRL, 32'h1, 4'hF);
        wr(MASK, 32'h1, 4'hF);
        step(8'hFB, 2'h0);
        step(8'hFA, 2'h1);
        rdc(CNT, 32'h1);
        rdc(STAT, 32'h1);
        chk({31'h0, irq}, 32'h1);
        step(8'h1E, 2'h0);
        step(8'h1F, 2'h2);
        rdc(STAT, 32'h3);
        wr(STAT, 32'h1, 4'hF);
        rdc(STAT, 32'h2);
        chk({31'h0, irq}, 32'h0);
        wr(STAT, 32'h2, 4'hF);
        rdc(STAT, 32'h0);
        wr(CNT, 32'hFF, 4'hF);
        rdc(CNT, 32'h1);
        for (int i = 0; i < 254; i++) begin
            step(8'h00, 2'h0);
            step(8'hFA, 2'h1);
        end
        rdc(CNT, 32'hFF);
        step(8'h00, 2'h0);
        step(8'hFA, 2'h1);
        rdc(CNT, 32'h0);
        wr(CTRL, 32'h0, 4'hF);
        step(8'h00, 2'h0);
        step(8'hFA, 2'h1);
        rdc(CNT, 32'h0);
        summarize();
    end
endmodule // temp_threshold_compare_counter_bench
